/* File: verilog/valley_pkg.sv */
// Purpose: shared constants and carrier types for the valley switching controller
// Assumes: mclk at 25 MHz, comparator results synchronous unless noted
// Notes: times are kept in their own unit, cycle counts derive from them
package valley_pkg;
   localparam int unsigned CLK_KHZ = 25000;
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned SS_TIME_MS = 12;
   localparam int unsigned SS_STEPS = 4;
   localparam int unsigned SS_STEP_CYCLES = SS_TIME_MS * CLK_KHZ / SS_STEPS;
   localparam int unsigned PERIOD_MS = 48;
   localparam int unsigned PERIOD_CYCLES = PERIOD_MS * CLK_KHZ;
   localparam int unsigned SHORT_SUPPRESS_NS = 2500;
   localparam int unsigned LONG_SUPPRESS_NS = 25000;
   localparam int unsigned SHORT_SUPPRESS_CYCLES = (SHORT_SUPPRESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LONG_SUPPRESS_CYCLES = (LONG_SUPPRESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MAX_OFF_NS = 50000;
   localparam int unsigned MAX_OFF_CYCLES = MAX_OFF_NS / CLK_PERIOD_NS;
   localparam int unsigned OVP_BLANK_NS = 1000;
   localparam int unsigned OVP_BLANK_CYCLES = (OVP_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TIMER_W = 21;
   localparam int unsigned LIMIT_W = 10;
   localparam int unsigned SS_START_MV = 320;
   localparam int unsigned SS_FINAL_MV = 1000;
   localparam logic [2:0] VALLEY_MIN = 3'h1;
   localparam logic [2:0] VALLEY_MAX = 3'h7;
   localparam logic [2:0] CROSS_MAX = 3'h7;

   typedef struct packed {
      logic reset;
      logic down;
      logic up;
   } fb_cmp_t;

   typedef struct packed {
      logic crossing;
      logic ovp;
      logic suppression;
   } aux_cmp_t;

   typedef enum logic [2:0] {
      ST_WAIT = 3'h0,
      ST_ON = 3'h1,
      ST_SUPPRESS = 3'h2,
      ST_VALLEY = 3'h3,
      ST_LATCHED = 3'h4
   } gate_state_t;

   function automatic logic [LIMIT_W-1:0] ss_limit(input logic [1:0] step);
      int unsigned mv;
      mv = SS_START_MV + 32'(step) * (SS_FINAL_MV - SS_START_MV) / (SS_STEPS - 1);
      return LIMIT_W'(mv);
   endfunction : ss_limit
endpackage : valley_pkg

/* File: verilog/crossing_counter.sv */
// Purpose: counts falling crossings of the aux sense comparator while off
// Assumes: crossing_above is asynchronous to mclk
// Notes: clear has priority, it coincides with the gate turning on
`timescale 1ns/1ps
module crossing_counter
   import valley_pkg::*;
(
   input wire logic mclk,
   input wire logic rst,
   input wire logic crossing_above,
   input wire logic count_enable,
   input wire logic clear,
   output logic [2:0] crossing_count
);
   logic sync1;
   logic sync2;
   logic prev;
   logic fall;
   logic [2:0] next_count;

   assign fall = prev & ~sync2;

   always_comb begin
      next_count = crossing_count;
      if (clear) begin
         next_count = 3'h0;
      end else if (count_enable && fall && crossing_count < CROSS_MAX) begin
         next_count = crossing_count + 3'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         prev <= 1'b0;
         crossing_count <= 3'h0;
      end else begin
         sync1 <= crossing_above;
         sync2 <= sync1;
         prev <= sync2;
         crossing_count <= next_count;
      end
   end

   a_crossing_clear: assert property (@(posedge mclk) disable iff (rst) clear |=> crossing_count == 3'h0)
      else $error("crossing count not cleared at turn-on");
   a_crossing_inc: assert property (@(posedge mclk) disable iff (rst)
      !clear && count_enable && fall && crossing_count < CROSS_MAX |=> crossing_count == $past(crossing_count) + 3'h1)
      else $error("crossing not counted");
   a_crossing_sat: assert property (@(posedge mclk) disable iff (rst)
      crossing_count == CROSS_MAX && !clear |=> crossing_count == CROSS_MAX)
      else $error("crossing count left its range");
endmodule : crossing_counter

/* File: verilog/valley_select_counter.sv */
// Purpose: valley select up/down counter updated once per feedback period
// Assumes: feedback comparator flags synchronous to mclk
// Notes: flags seen in the final cycle still belong to the ending period
`timescale 1ns/1ps
module valley_select_counter
   import valley_pkg::*;
#(
   parameter int unsigned PERIOD_CYCLES_P = PERIOD_CYCLES
)(
   input wire logic mclk,
   input wire logic rst,
   input wire fb_cmp_t feedback_level,
   output logic [2:0] valley_count
);
   logic [TIMER_W-1:0] period_timer;
   logic [TIMER_W-1:0] next_timer;
   fb_cmp_t seen;
   fb_cmp_t next_seen;
   fb_cmp_t hits;
   logic period_end;
   logic [2:0] next_count;

   always_comb begin
      period_end = period_timer == TIMER_W'(PERIOD_CYCLES_P - 1);
      hits = fb_cmp_t'(seen | feedback_level);
      next_timer = period_end ? '0 : period_timer + 1'b1;
      next_seen = period_end ? fb_cmp_t'(3'h0) : hits;
      next_count = valley_count;
      if (period_end) begin
         if (hits.reset) begin
            next_count = VALLEY_MIN;
         end else if (hits.down) begin
            if (valley_count > VALLEY_MIN) begin
               next_count = valley_count - 3'h1;
            end
         end else if (hits.up) begin
            next_count = valley_count;
         end else if (valley_count < VALLEY_MAX) begin
            next_count = valley_count + 3'h1;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         period_timer <= '0;
         seen <= fb_cmp_t'(3'h0);
         valley_count <= VALLEY_MIN;
      end else begin
         period_timer <= next_timer;
         seen <= next_seen;
         valley_count <= next_count;
      end
   end

   a_valley_range: assert property (@(posedge mclk) disable iff (rst)
      valley_count >= VALLEY_MIN && valley_count <= VALLEY_MAX)
      else $error("valley count out of range");
   a_valley_once: assert property (@(posedge mclk) disable iff (rst) !period_end |=> $stable(valley_count))
      else $error("valley count changed inside a period");
   a_valley_reset: assert property (@(posedge mclk) disable iff (rst)
      period_end && hits.reset |=> valley_count == VALLEY_MIN)
      else $error("valley count not forced to minimum");
   a_valley_up: assert property (@(posedge mclk) disable iff (rst)
      period_end && hits == fb_cmp_t'(3'h0) |=> valley_count == (($past(valley_count) == VALLEY_MAX) ?
      VALLEY_MAX : $past(valley_count) + 3'h1))
      else $error("valley count did not step up");
   a_valley_hold: assert property (@(posedge mclk) disable iff (rst)
      period_end && hits.up && !hits.down && !hits.reset |=> $stable(valley_count))
      else $error("valley count did not hold");
   a_valley_down: assert property (@(posedge mclk) disable iff (rst)
      period_end && hits.down && !hits.reset |=> valley_count == (($past(valley_count) == VALLEY_MIN) ?
      VALLEY_MIN : $past(valley_count) - 3'h1))
      else $error("valley count did not step down");
   a_valley_init: assert property (@(posedge mclk) $past(rst) && !rst |-> valley_count == VALLEY_MIN)
      else $error("valley count not minimum after reset");
endmodule : valley_select_counter

/* File: verilog/valley_switch_freq_reduction.sv */
// Purpose: soft-start, gate switch-on timing, ringing suppression and overvoltage latch
// Assumes: comparator inputs synchronous to mclk except the crossing comparator
// Notes: switch-off comes from the analog current path as switch_off_request
`timescale 1ns/1ps
module valley_switch_freq_reduction
   import valley_pkg::*;
#(
   parameter int unsigned SS_STEP_CYCLES_P = SS_STEP_CYCLES,
   parameter int unsigned PERIOD_CYCLES_P = PERIOD_CYCLES,
   parameter int unsigned SHORT_SUPPRESS_CYCLES_P = SHORT_SUPPRESS_CYCLES,
   parameter int unsigned LONG_SUPPRESS_CYCLES_P = LONG_SUPPRESS_CYCLES,
   parameter int unsigned MAX_OFF_CYCLES_P = MAX_OFF_CYCLES,
   parameter int unsigned OVP_BLANK_CYCLES_P = OVP_BLANK_CYCLES
)(
   input wire logic mclk,
   input wire logic rst,
   input wire logic supply_above_on,
   input wire fb_cmp_t feedback_level,
   input wire aux_cmp_t aux_sense_input,
   input wire logic switch_off_request,
   input wire logic [LIMIT_W-1:0] other_limit_mv,
   input wire logic [1:0] line_level,
   output logic gate_drive_output,
   output logic startup_cell_enable,
   output logic [LIMIT_W-1:0] cs_limit_mv,
   output logic soft_start_done,
   output logic [2:0] valley_count,
   output logic [2:0] crossing_count,
   output logic [1:0] count_up_threshold_sel,
   output logic [1:0] count_down_threshold_sel,
   output logic latched_off
);
   gate_state_t state;
   gate_state_t next_state;
   logic [TIMER_W-1:0] supp_timer;
   logic [TIMER_W-1:0] next_supp;
   logic [TIMER_W-1:0] off_timer;
   logic [TIMER_W-1:0] next_off;
   logic [TIMER_W-1:0] ovp_timer;
   logic [TIMER_W-1:0] next_ovp;
   logic next_gate;
   logic next_startup;
   logic next_latched;
   logic turn_on;
   logic off_phase;
   logic ovp_trip;
   logic max_off_hit;
   logic [TIMER_W-1:0] ss_timer;
   logic [TIMER_W-1:0] next_ss_timer;
   logic [1:0] ss_step;
   logic [1:0] next_ss_step;
   logic next_ss_done;
   logic [LIMIT_W-1:0] step_mv;
   logic [LIMIT_W-1:0] next_cs_limit;
   logic [1:0] next_up_sel;
   logic [1:0] next_down_sel;

   valley_select_counter #(
      .PERIOD_CYCLES_P(PERIOD_CYCLES_P)
   ) u_valley (
      .mclk(mclk),
      .rst(rst),
      .feedback_level(feedback_level),
      .valley_count(valley_count)
   );

   crossing_counter u_crossing (
      .mclk(mclk),
      .rst(rst),
      .crossing_above(aux_sense_input.crossing),
      .count_enable(off_phase),
      .clear(turn_on),
      .crossing_count(crossing_count)
   );

   // gate sequencing
   always_comb begin
      next_state = state;
      next_supp = supp_timer;
      next_off = off_timer;
      next_ovp = ovp_timer;
      off_phase = state == ST_SUPPRESS || state == ST_VALLEY;
      ovp_trip = aux_sense_input.ovp && ovp_timer == TIMER_W'(OVP_BLANK_CYCLES_P - 1);
      max_off_hit = off_timer == TIMER_W'(MAX_OFF_CYCLES_P - 1);
      unique case (state)
         ST_WAIT: begin
            if (supply_above_on) begin
               next_state = ST_ON;
            end
         end
         ST_ON: begin
            if (switch_off_request) begin
               next_state = ST_SUPPRESS;
               next_off = '0;
               next_ovp = '0;
               if (aux_sense_input.suppression) begin
                  next_supp = TIMER_W'(SHORT_SUPPRESS_CYCLES_P - 1);
               end else begin
                  next_supp = TIMER_W'(LONG_SUPPRESS_CYCLES_P - 1);
               end
            end
         end
         ST_SUPPRESS, ST_VALLEY: begin
            next_off = off_timer + 1'b1;
            next_ovp = aux_sense_input.ovp ? ovp_timer + 1'b1 : '0;
            if (ovp_trip) begin
               next_state = ST_LATCHED;
            end else if (max_off_hit) begin
               next_state = ST_ON;
            end else if (state == ST_SUPPRESS) begin
               if (supp_timer == '0) begin
                  next_state = ST_VALLEY;
               end else begin
                  next_supp = supp_timer - 1'b1;
               end
            end else if (crossing_count >= valley_count) begin
               next_state = ST_ON;
            end
         end
         ST_LATCHED: begin
            next_state = ST_LATCHED;
         end
         default: begin
            next_state = ST_WAIT;
         end
      endcase
      turn_on = state != ST_ON && next_state == ST_ON;
      next_gate = next_state == ST_ON;
      next_startup = next_state == ST_WAIT;
      next_latched = next_state == ST_LATCHED;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= ST_WAIT;
         supp_timer <= '0;
         off_timer <= '0;
         ovp_timer <= '0;
         gate_drive_output <= 1'b0;
         startup_cell_enable <= 1'b1;
         latched_off <= 1'b0;
      end else begin
         state <= next_state;
         supp_timer <= next_supp;
         off_timer <= next_off;
         ovp_timer <= next_ovp;
         gate_drive_output <= next_gate;
         startup_cell_enable <= next_startup;
         latched_off <= next_latched;
      end
   end

   // soft-start limit and threshold selection
   always_comb begin
      next_ss_timer = ss_timer;
      next_ss_step = ss_step;
      next_ss_done = soft_start_done;
      if (state != ST_WAIT && !soft_start_done) begin
         if (ss_timer == TIMER_W'(SS_STEP_CYCLES_P - 1)) begin
            next_ss_timer = '0;
            if (ss_step == 2'(SS_STEPS - 1)) begin
               next_ss_done = 1'b1;
            end else begin
               next_ss_step = ss_step + 2'h1;
            end
         end else begin
            next_ss_timer = ss_timer + 1'b1;
         end
      end
      step_mv = ss_limit(next_ss_step);
      next_cs_limit = (other_limit_mv < step_mv) ? other_limit_mv : step_mv;
      next_up_sel = line_level;
      next_down_sel = line_level;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ss_timer <= '0;
         ss_step <= 2'h0;
         soft_start_done <= 1'b0;
         cs_limit_mv <= '0;
         count_up_threshold_sel <= 2'h0;
         count_down_threshold_sel <= 2'h0;
      end else begin
         ss_timer <= next_ss_timer;
         ss_step <= next_ss_step;
         soft_start_done <= next_ss_done;
         cs_limit_mv <= next_cs_limit;
         count_up_threshold_sel <= next_up_sel;
         count_down_threshold_sel <= next_down_sel;
      end
   end

   // soft-start elapsed time for checking
   int unsigned ss_elapsed;
   always_ff @(posedge mclk) begin
      if (rst) begin
         ss_elapsed <= 0;
      end else if (state != ST_WAIT && !soft_start_done) begin
         ss_elapsed <= ss_elapsed + 1;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   a_startup_handoff: assert property (state == ST_WAIT && supply_above_on |=> gate_drive_output && !startup_cell_enable)
      else $error("switching did not start at supply turn-on");
   a_startup_hold: assert property (state == ST_WAIT |-> startup_cell_enable && !gate_drive_output)
      else $error("startup path not active before turn-on");
   a_ss_total: assert property ($rose(soft_start_done) |-> ss_elapsed == SS_STEPS * SS_STEP_CYCLES_P)
      else $error("soft-start length wrong");
   a_ss_step: assert property ($changed(ss_step) |-> ss_timer == '0 && ss_step == $past(ss_step) + 2'h1)
      else $error("soft-start step out of order");
   a_limit_bound: assert property (1'b1 |=> cs_limit_mv <= $past(other_limit_mv) && cs_limit_mv <= ss_limit(ss_step))
      else $error("current limit above its bound");
   a_limit_final: assert property (soft_start_done && other_limit_mv >= LIMIT_W'(SS_FINAL_MV)
      |=> cs_limit_mv == LIMIT_W'(SS_FINAL_MV))
      else $error("final current limit not reached");
   a_switch_cause: assert property ($rose(gate_drive_output) |-> $past(state) == ST_WAIT || $past(max_off_hit) ||
      $past(crossing_count) >= $past(valley_count))
      else $error("gate turned on without a cause");
   a_supp_long: assert property (state == ST_ON && switch_off_request && !aux_sense_input.suppression
      |=> supp_timer == TIMER_W'(LONG_SUPPRESS_CYCLES_P - 1))
      else $error("long suppression not selected");
   a_supp_short: assert property (state == ST_ON && switch_off_request && aux_sense_input.suppression
      |=> supp_timer == TIMER_W'(SHORT_SUPPRESS_CYCLES_P - 1))
      else $error("short suppression not selected");
   a_valley_on: assert property (state == ST_VALLEY && crossing_count >= valley_count |=> gate_drive_output || latched_off)
      else $error("gate not turned on at valley");
   a_no_early_on: assert property (state == ST_SUPPRESS && !max_off_hit |=> !gate_drive_output)
      else $error("gate turned on during suppression");
   a_max_off: assert property (off_phase && max_off_hit |=> gate_drive_output || latched_off)
      else $error("maximum off time not enforced");
   a_ovp_latch: assert property (off_phase && ovp_trip |=> latched_off && !gate_drive_output [*2])
      else $error("overvoltage did not latch off");
   a_latch_keep: assert property (latched_off |=> latched_off && !gate_drive_output)
      else $error("latch-off released");
   a_cross_clear: assert property ($rose(gate_drive_output) |-> crossing_count == 3'h0)
      else $error("crossing count not cleared");
   a_thresh_sel: assert property (1'b1 |=> count_up_threshold_sel == $past(line_level))
      else $error("threshold select not following line level");
   a_down_sel: assert property (
      1'b1 |=> count_down_threshold_sel == $past(line_level))
      else $error("down threshold select not following line level");

   // startup and soft-start state
   a_startup_state: assert property (
      startup_cell_enable == (state == ST_WAIT))
      else $error("startup path does not match waiting state");
   a_startup_stays: assert property (
      !startup_cell_enable |=> !startup_cell_enable)
      else $error("startup path turned on again");
   a_wait_no_ss: assert property (
      state == ST_WAIT |-> ss_timer == '0 && ss_step == 2'h0)
      else $error("soft-start ran before turn-on");
   a_ss_timer_range: assert property (
      ss_timer < TIMER_W'(SS_STEP_CYCLES_P))
      else $error("soft-start step timer out of range");
   a_ss_done_keep: assert property (
      soft_start_done |=> soft_start_done)
      else $error("soft-start done dropped");
   a_ss_last_step: assert property (
      soft_start_done |-> ss_step == 2'(SS_STEPS - 1))
      else $error("soft-start ended before last step");
   a_cs_upper: assert property (
      cs_limit_mv <= LIMIT_W'(SS_FINAL_MV))
      else $error("current limit above final value");

   // gate timing
   a_gate_state: assert property (
      gate_drive_output == (state == ST_ON))
      else $error("gate does not match on state");
   a_gate_stays_on: assert property (
      state == ST_ON && !switch_off_request |=> gate_drive_output)
      else $error("gate dropped without switch-off request");
   a_gate_off_req: assert property (
      state == ST_ON && switch_off_request |=> !gate_drive_output && off_timer == '0)
      else $error("switch-off request not taken");
   a_supp_count: assert property (
      state == ST_SUPPRESS && supp_timer != '0 && !ovp_trip && !max_off_hit
      |=> state == ST_SUPPRESS && supp_timer == $past(supp_timer) - 1'b1)
      else $error("suppression timer not counting down");
   a_supp_expire: assert property (
      state == ST_SUPPRESS && supp_timer == '0 && !ovp_trip && !max_off_hit |=> state == ST_VALLEY)
      else $error("suppression did not expire into valley wait");
   a_off_bound: assert property (
      off_phase |-> off_timer < TIMER_W'(MAX_OFF_CYCLES_P))
      else $error("off timer past maximum off time");
   a_ovp_blank: assert property (
      off_phase && aux_sense_input.ovp && !ovp_trip |=> !latched_off)
      else $error("latched off before blanking ended");
   a_latch_state: assert property (
      state == ST_LATCHED |-> latched_off && !gate_drive_output)
      else $error("latched state with gate on");

   c_valley_on: cover property (state == ST_VALLEY ##1 gate_drive_output);
   c_max_off: cover property (off_phase && max_off_hit ##1 gate_drive_output);
   c_latch: cover property ($rose(latched_off));
   c_ss_done: cover property ($rose(soft_start_done));
   c_short_supp: cover property (state == ST_ON && switch_off_request && aux_sense_input.suppression);
endmodule : valley_switch_freq_reduction

/* File: dv/aux_winding_model.sv */
// Purpose: far-side model of the aux winding ringing and overvoltage seen through comparators
// Assumes: gate_drive_output high means the switch is on
// Notes: ringing gives n_cross falling crossings four cycles apart, then settles low
`timescale 1ns/1ps
module aux_winding_model
   import valley_pkg::*;
(
   input wire logic mclk,
   input wire logic gate_drive_output,
   input wire logic [3:0] n_cross,
   input wire logic supp_lvl,
   input wire logic ovp_lvl,
   output aux_cmp_t aux_sense_input
);
   int t = 0;
   always @(posedge mclk) begin
      if (gate_drive_output) t <= 0;
      else t <= t + 1;
   end
   // clamped low while on, rings while off
   assign aux_sense_input = aux_cmp_t'({!gate_drive_output && (t < 4 * int'(n_cross)) && (t % 4 < 2),
      ovp_lvl && !gate_drive_output, supp_lvl});
endmodule : aux_winding_model

/* File: dv/valley_switch_freq_reduction_test.sv */
// Purpose: self-checking bench for the valley switching controller
// Assumes: shortened timer parameters, inputs driven 1 ns after the rising edge
// Notes: valley count notes are queued by run_period and checked mid next period
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module valley_switch_freq_reduction_test;
   import valley_pkg::*;
   localparam int unsigned SS_P = 20;
   localparam int unsigned PER_P = 50;
   localparam int unsigned SHORT_P = 3;
   localparam int unsigned LONG_P = 12;
   localparam int unsigned MOFF_P = 40;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic supply_above_on = 1'b0;
   fb_cmp_t feedback_level = 3'h7;
   aux_cmp_t aux_sense_input;
   logic switch_off_request = 1'b0;
   logic [LIMIT_W-1:0] other_limit_mv = '1;
   logic [1:0] line_level = 2'h0;
   logic gate_drive_output, startup_cell_enable, soft_start_done, latched_off;
   logic [LIMIT_W-1:0] cs_limit_mv;
   logic [2:0] valley_count, crossing_count;
   logic [1:0] count_up_threshold_sel, count_down_threshold_sel, prev_line;
   logic [3:0] n_cross = 4'h0;
   logic supp_lvl = 1'b0;
   logic ovp_lvl = 1'b0;
   logic [2:0] vexp = 3'h1;
   logic [2:0] notes[$];
   logic [2:0] nv;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   int low;
   logic [2:0] lastc;

   valley_switch_freq_reduction #(.SS_STEP_CYCLES_P(SS_P), .PERIOD_CYCLES_P(PER_P),
      .SHORT_SUPPRESS_CYCLES_P(SHORT_P), .LONG_SUPPRESS_CYCLES_P(LONG_P),
      .MAX_OFF_CYCLES_P(MOFF_P), .OVP_BLANK_CYCLES_P(4)) u_valley_switch_freq_reduction (
      .mclk, .rst, .supply_above_on, .feedback_level, .aux_sense_input, .switch_off_request,
      .other_limit_mv, .line_level, .gate_drive_output, .startup_cell_enable, .cs_limit_mv,
      .soft_start_done, .valley_count, .crossing_count, .count_up_threshold_sel,
      .count_down_threshold_sel, .latched_off);
   aux_winding_model u_aux_winding_model (.mclk, .gate_drive_output, .n_cross, .supp_lvl,
      .ovp_lvl, .aux_sense_input);

   always #20 mclk = ~mclk;

   // watcher: cycle count, queued valley notes, threshold selects
   always @(posedge mclk) begin
      cyc <= rst ? 0 : cyc + 1;
      prev_line <= line_level;
      if (!rst && cyc > 0) begin
         `CHK("up_sel", prev_line, count_up_threshold_sel)
         `CHK("down_sel", prev_line, count_down_threshold_sel)
      end
      if (!rst && cyc % PER_P == 25 && notes.size() > 0) begin
         nv = notes.pop_front();
         `CHK("valley_count", nv, valley_count)
      end
      if (!rst) line_level <= #1 2'($urandom);
   end

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step

   task automatic run_period(input int cat);
      int g;
      g = 0;
      while (cyc % PER_P != 5 && g < 200) begin
         step(1);
         g++;
      end
      feedback_level = (cat == 0) ? 3'h0 : (cat == 1) ? 3'h1 : (cat == 2) ? 3'h3 : 3'h7;
      step(10);
      feedback_level = 3'h0;
      step(30);
      case (cat)
         0: vexp = (vexp == 3'h7) ? vexp : vexp + 3'h1;
         2: vexp = (vexp == 3'h1) ? vexp : vexp - 3'h1;
         3: vexp = 3'h1;
         default: vexp = vexp;
      endcase
      notes.push_back(vexp);
   endtask : run_period

   task automatic off_run(input logic s, input logic [3:0] n);
      supp_lvl = s;
      n_cross = n;
      low = 0;
      lastc = 3'h0;
      switch_off_request = 1'b1;
      step(1);
      switch_off_request = 1'b0;
      while (gate_drive_output === 1'b0 && low < 100) begin
         lastc = crossing_count;
         low++;
         step(1);
      end
   endtask : off_run

   task automatic close_out();
      if (num_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : close_out

   initial begin
      #(4000 * 40);
      num_errors++;
      close_out();
   end

   initial begin
      void'($urandom(32'h2BB0575A));
      step(2);
      rst = 1'b0;
      `CHK("valley_init", 3'h1, valley_count)
      `CHK("gate_init", 1'b0, gate_drive_output)
      `CHK("startup_init", 1'b1, startup_cell_enable)
      supply_above_on = 1'b1;
      step(2);
      `CHK("gate_start", 1'b1, gate_drive_output)
      `CHK("startup_off", 1'b0, startup_cell_enable)
      for (int k = 0; k < 4; k++) begin
         step(k == 0 ? SS_P / 2 : SS_P);
         `CHK("cs_limit", LIMIT_W'(SS_START_MV + k * (SS_FINAL_MV - SS_START_MV) / 3), cs_limit_mv)
         `CHK("ss_done_early", 1'b0, soft_start_done)
      end
      step(SS_P);
      `CHK("ss_done", 1'b1, soft_start_done)
      `CHK("cs_final", LIMIT_W'(SS_FINAL_MV), cs_limit_mv)
      other_limit_mv = LIMIT_W'(200 + $urandom_range(300));
      step(2);
      `CHK("cs_other", other_limit_mv, cs_limit_mv)
      other_limit_mv = '1;
      off_run(1'b1, 4'h1);
      `CHK("short_supp", 1'b1, low > SHORT_P && low <= LONG_P)
      off_run(1'b0, 4'h1);
      `CHK("long_supp", LONG_P + 1, low)
      `CHK("cross_clear", 3'h0, crossing_count)
      run_period(3);
      repeat (7) run_period(0);
      run_period(1);
      run_period(2);
      run_period(3);
      run_period(2);
      repeat (4) run_period($urandom_range(3));
      repeat (6) run_period(0);
      step(30);
      off_run(1'b1, 4'h6);
      `CHK("max_off", MOFF_P, low)
      `CHK("cross_six", 3'h6, lastc)
      off_run(1'b1, 4'h7);
      `CHK("valley_on", 1'b1, low < MOFF_P)
      `CHK("cross_seven", 3'h7, lastc)
      `CHK("cross_clear2", 3'h0, crossing_count)
      ovp_lvl = 1'b1;
      off_run(1'b1, 4'h0);
      `CHK("ovp_hold", 100, low)
      `CHK("latched", 1'b1, latched_off)
      close_out();
   end
endmodule : valley_switch_freq_reduction_test
